/* File: daq_card_io_register_map.sv */
// Host-visible I/O register bank of the acquisition card.
// Assumes the bus bridge delivers single 32-bit accesses with a full address and
// forwards configuration accesses for the base register on their own strobes.
`timescale 1ns/1ns
`default_nettype none
module daq_card_io_register_map #(
  parameter int DIO_W  = 16,
  parameter int CODE_W = 12
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  // Configuration side of the base range.
  input  wire logic              cfg_wr_i,
  input  wire logic              cfg_rd_i,
  input  wire logic [31:0]       cfg_wdata_i,
  output logic      [31:0]       cfg_rdata_o,
  output logic      [7:0]        irq_pin_o,
  input  wire logic              master_en_i,
  // Register access port.
  input  wire logic              req_i,
  input  wire logic              we_i,
  input  wire logic [31:0]       addr_i,
  input  wire logic [31:0]       wdata_i,
  output logic      [31:0]       rdata_o,
  output logic                   ack_o,
  output logic                   hit_o,
  // Timer/counter chip.
  output logic                   tmr_wr_o,
  output logic                   tmr_rd_o,
  output logic      [1:0]        tmr_sel_o,
  output logic      [7:0]        tmr_wdata_o,
  input  wire logic [7:0]        tmr_rdata_i,
  input  wire logic              pacer_tick_i,
  input  wire logic              ext_trig_i,
  // Converter side.
  output logic                   conv_start_o,
  output logic      [3:0]        mux_sel_o,
  output logic      [3:0]        gain_o,
  input  wire logic              conv_done_i,
  input  wire logic [CODE_W-1:0] conv_code_i,
  input  wire logic [3:0]        conv_chan_i,
  output logic                   irq_o,
  // Burst words toward host memory.
  output logic                   dma_valid_o,
  output logic      [31:0]       dma_data_o,
  input  wire logic              dma_ready_i,
  // Output converters and digital lines.
  output logic      [CODE_W-1:0] dac1_o,
  output logic      [CODE_W-1:0] dac2_o,
  input  wire logic [DIO_W-1:0]  din_i,
  output logic      [DIO_W-1:0]  dout_o
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic [31:0] base_q;
  logic [5:0]  off;
  logic        hit;
  logic        wr;
  logic        rd;

  // The base window is 64 bytes; only the offset bits take part past the compare.
  assign off = addr_i[5:0];
  assign hit = req_i && ((addr_i & daq_io_pkg::BAR_MASK) == (base_q & daq_io_pkg::BAR_MASK));
  assign wr  = ce_i && hit && we_i;
  assign rd  = ce_i && hit && !we_i;
  assign hit_o = hit;

  function automatic logic is_off(input logic [5:0] a, input logic [5:0] o);
    is_off = (a == o);
  endfunction : is_off

  // ---------------------------------------------------------------
  // Configuration space
  // ---------------------------------------------------------------
  // Firmware sizes the range by writing ones and reading back the mask.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      base_q <= daq_io_pkg::BASE_RESET;
    end else if (ce_i && cfg_wr_i) begin
      base_q <= cfg_wdata_i & daq_io_pkg::BAR_MASK;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cfg_rdata_o <= daq_io_pkg::BAR_IO_FLAG;
    end else if (ce_i && cfg_rd_i) begin
      cfg_rdata_o <= base_q | daq_io_pkg::BAR_IO_FLAG;
    end
  end

  assign irq_pin_o = daq_io_pkg::IRQ_PIN;

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic [12:0] ctl_q;
  logic [3:0]  mode;
  logic        scan_en;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctl_q <= daq_io_pkg::CTL_RESET;
    end else if (wr && is_off(off, daq_io_pkg::OFF_STAT_CTL)) begin
      ctl_q <= wdata_i[12:0];
    end
  end

  assign mode    = ctl_q[daq_io_pkg::CTL_MODE_LSB +: 4];
  assign scan_en = ctl_q[daq_io_pkg::CTL_SCAN_BIT];
  assign gain_o  = ctl_q[daq_io_pkg::CTL_GAIN_LSB +: 4];

  // ---------------------------------------------------------------
  // Channel sequencing
  // ---------------------------------------------------------------
  // In scan mode the channel walks down from the programmed one to zero and wraps.
  logic [3:0] chan_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      chan_q <= 4'h0;
    end else if (ce_i) begin
      if (wr && is_off(off, daq_io_pkg::OFF_STAT_CTL)) begin
        chan_q <= wdata_i[daq_io_pkg::CTL_MUX_LSB +: 4];
      end else if (conv_done_i && scan_en) begin
        chan_q <= (chan_q == 4'h0) ? ctl_q[daq_io_pkg::CTL_MUX_LSB +: 4] : chan_q - 4'h1;
      end
    end
  end

  assign mux_sel_o = chan_q;

  // ---------------------------------------------------------------
  // Trigger source
  // ---------------------------------------------------------------
  // Only the selected source may start a conversion; the others are ignored.
  logic kick;
  logic start_d;
  logic start_q;

  assign kick = wr && is_off(off, daq_io_pkg::OFF_KICK);

  always_comb begin
    if (mode[daq_io_pkg::MODE_EXT_BIT]) begin
      start_d = ext_trig_i;
    end else if (mode[daq_io_pkg::MODE_TMR_BIT]) begin
      start_d = pacer_tick_i;
    end else begin
      start_d = kick;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      start_q <= 1'b0;
    end else if (ce_i) begin
      start_q <= start_d;
    end
  end

  assign conv_start_o = start_q;

  // ---------------------------------------------------------------
  // Result register and status
  // ---------------------------------------------------------------
  logic [31:0] result_q;
  logic        drdy_q;
  logic        dovr_q;
  logic        res_rd;
  logic        dma_mode;

  assign res_rd   = rd && is_off(off, daq_io_pkg::OFF_ADC_DAC1);
  assign dma_mode = mode[daq_io_pkg::MODE_DMA_BIT] && master_en_i;

  // Code in bits 15..4 with its channel in 3..0; upper half reads as zero.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      result_q <= 32'h0000_0000;
    end else if (ce_i && conv_done_i) begin
      result_q <= {16'h0000, conv_code_i, conv_chan_i};
    end
  end

  // A new result in the same cycle as the read keeps ready set.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      drdy_q <= 1'b0;
    end else if (ce_i) begin
      if (conv_done_i) begin
        drdy_q <= 1'b1;
      end else if (res_rd || (dma_valid_o && dma_ready_i)) begin
        drdy_q <= 1'b0;
      end
    end
  end

  // Over-run is only meaningful in bus-master mode; cleared by a status read.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dovr_q <= 1'b0;
    end else if (ce_i) begin
      if (conv_done_i && dma_mode && dma_valid_o && !dma_ready_i) begin
        dovr_q <= 1'b1;
      end else if (rd && is_off(off, daq_io_pkg::OFF_STAT_CTL)) begin
        dovr_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Burst words toward host memory
  // ---------------------------------------------------------------
  // One word of holding; a stalled master shows up as over-run, not lost order.
  logic dma_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dma_q <= 1'b0;
    end else if (ce_i) begin
      if (conv_done_i && dma_mode) begin
        dma_q <= 1'b1;
      end else if (dma_ready_i) begin
        dma_q <= 1'b0;
      end
    end
  end

  assign dma_valid_o = dma_q;
  assign dma_data_o  = result_q;

  assign irq_o = drdy_q && mode[daq_io_pkg::MODE_INT_BIT];

  // ---------------------------------------------------------------
  // Output converters and digital output
  // ---------------------------------------------------------------
  logic [CODE_W-1:0] dac1_q;
  logic [CODE_W-1:0] dac2_q;
  logic [DIO_W-1:0]  dout_q;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dac1_q <= daq_io_pkg::DAC_RESET;
    end else if (wr && is_off(off, daq_io_pkg::OFF_ADC_DAC1)) begin
      dac1_q <= wdata_i[CODE_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dac2_q <= daq_io_pkg::DAC_RESET;
    end else if (wr && is_off(off, daq_io_pkg::OFF_DAC2)) begin
      dac2_q <= wdata_i[CODE_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dout_q <= daq_io_pkg::DOUT_RESET;
    end else if (wr && is_off(off, daq_io_pkg::OFF_DIO)) begin
      dout_q <= wdata_i[DIO_W-1:0];
    end
  end

  assign dac1_o = dac1_q;
  assign dac2_o = dac2_q;
  assign dout_o = dout_q;

  // ---------------------------------------------------------------
  // Timer chip access
  // ---------------------------------------------------------------
  // The timer sits on an 8-bit port; only the low byte of the word is passed.
  logic tmr_hit;

  assign tmr_hit = (off[5:4] == 2'b00);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tmr_wr_o    <= 1'b0;
      tmr_rd_o    <= 1'b0;
      tmr_sel_o   <= 2'b00;
      tmr_wdata_o <= 8'h00;
    end else if (ce_i) begin
      tmr_wr_o    <= wr && tmr_hit;
      tmr_rd_o    <= rd && tmr_hit && (off != daq_io_pkg::OFF_COUNTER_CTL);
      tmr_sel_o   <= off[3:2];
      tmr_wdata_o <= wdata_i[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Read mux and answer
  // ---------------------------------------------------------------
  // Write-only offsets and unmapped ones read as zero.
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (off)
      daq_io_pkg::OFF_COUNTER_0,
      daq_io_pkg::OFF_COUNTER_1,
      daq_io_pkg::OFF_COUNTER_2: rdata_d = {24'h00_0000, tmr_rdata_i};
      daq_io_pkg::OFF_ADC_DAC1:  rdata_d = result_q;
      daq_io_pkg::OFF_STAT_CTL: begin
        rdata_d[daq_io_pkg::STS_DRDY_BIT] = drdy_q;
        rdata_d[daq_io_pkg::STS_DOVR_BIT] = dovr_q;
      end
      daq_io_pkg::OFF_DIO:       rdata_d = {{(32-DIO_W){1'b0}}, din_i};
      default:                   rdata_d = 32'h0000_0000;
    endcase
  end

  // Every access that hits the window with ce_i high, read or write, gets a single answer one edge later.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ack_o   <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= hit;
      if (rd) begin
        rdata_o <= rdata_d;
      end
    end
  end

endmodule : daq_card_io_register_map
`default_nettype wire

/* File: daq_card_io_register_map_checker.sv */
// Concurrent checks on the ports of the card register map.
// Assumes it is bound into the register map; one clock, sync active-low reset.
`timescale 1ns/1ns
`default_nettype none
module daq_card_io_register_map_checker #(
  parameter int DIO_W  = 16,
  parameter int CODE_W = 12
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  input  wire logic              cfg_rd_i,
  input  wire logic [31:0]       cfg_rdata_o,
  input  wire logic [7:0]        irq_pin_o,
  input  wire logic              req_i,
  input  wire logic              we_i,
  input  wire logic [31:0]       addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic [31:0]       rdata_o,
  input  wire logic              ack_o,
  input  wire logic              hit_o,
  input  wire logic              conv_done_i,
  input  wire logic [CODE_W-1:0] conv_code_i,
  input  wire logic [3:0]        conv_chan_i,
  input  wire logic [CODE_W-1:0] dac1_o,
  input  wire logic [CODE_W-1:0] dac2_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ---------------------------------------------------------------
  // Accepted accesses
  // ---------------------------------------------------------------
  // Writes and reads that the map takes, keyed by offset.
  sequence s_wr(off);
    ce_i && req_i && we_i && hit_o && addr_i[5:0] == off;
  endsequence
  sequence s_rd(off);
    ce_i && req_i && !we_i && hit_o && addr_i[5:0] == off;
  endsequence
  a_ack_one_cycle: assert property (
    $past(ce_i) && $past(rst_n_i) |-> ack_o == $past(req_i && hit_o)) else $error("ack does not follow request");
  a_result_word_fields: assert property (
    ce_i && conv_done_i ##1 s_rd(6'h10) |=> rdata_o == {16'h0000, $past(conv_code_i, 2), $past(conv_chan_i, 2)})
    else $error("result word layout wrong");
  a_dac2_reads_zero: assert property (
    s_rd(6'h14) |=> rdata_o == 32'h0000_0000) else $error("output register readable");
  a_kick_reads_zero: assert property (
    s_rd(6'h20) |=> rdata_o == 32'h0000_0000) else $error("trigger offset readable");
  a_dac1_load: assert property (
    s_wr(6'h10) |=> dac1_o == $past(wdata_i[11:0])) else $error("channel one code not loaded");
  a_dac2_load: assert property (
    s_wr(6'h14) |=> dac2_o == $past(wdata_i[11:0])) else $error("channel two code not loaded");
  a_dac1_holds: assert property (
    !(ce_i && req_i && we_i && hit_o && addr_i[5:0] == 6'h10) |=> $stable(dac1_o))
    else $error("channel one code changed");
  a_cfg_io_flag: assert property (
    ce_i && cfg_rd_i |=> cfg_rdata_o[5:0] == 6'h01) else $error("base readback low bits wrong");
  a_irq_pin_req: assert property (
    irq_pin_o == 8'h01) else $error("interrupt pin request wrong");
endmodule : daq_card_io_register_map_checker
bind daq_card_io_register_map daq_card_io_register_map_checker #(.DIO_W(DIO_W), .CODE_W(CODE_W)) i_chk (.*);
`default_nettype wire

/* File: daq_card_io_register_map_tb_top.sv */
// Self-checking bench for the card register map with a converter model.
// Assumes the bench alone drives the register and configuration strobes.
`timescale 1ns/1ns
`default_nettype none
module daq_card_io_register_map_tb_top;
  logic        core_clk_i, rst_n_i, ce_i, cfg_wr_i, cfg_rd_i, master_en_i, req_i, we_i;
  logic        tmr_wr_o, tmr_rd_o, pacer_tick_i, ext_trig_i, conv_start_o, conv_done_i, irq_o;
  logic        ack_o, hit_o, dma_valid_o, dma_ready_i;
  logic [31:0] cfg_wdata_i, cfg_rdata_o, addr_i, wdata_i, rdata_o, dma_data_o, base, rd, wd;
  logic [7:0]  irq_pin_o, tmr_wdata_o, tmr_rdata_i;
  logic [1:0]  tmr_sel_o;
  logic [3:0]  mux_sel_o, gain_o, conv_chan_i, lat, ch, chs, g;
  logic [11:0] conv_code_i, dac1_o, dac2_o, code;
  logic [15:0] din_i, dout_o;
  int          mismatches, comparisons, n;
  daq_card_io_register_map #(.DIO_W(16), .CODE_W(12)) i_dut (.*);
  daq_conv_model i_conv (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .start_i(conv_start_o), .chan_i(mux_sel_o),
    .lat_i(lat), .done_o(conv_done_i), .code_o(conv_code_i), .chan_o(conv_chan_i), .tmr_o(tmr_rdata_i));
  // ---------------------------------------------------------------
  // Clock, capture, checks
  // ---------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  // Sample kept from the model's done pulse, the basis of every expected result word.
  always @(posedge core_clk_i) begin
    if (conv_done_i) begin
      code <= conv_code_i;
      chs  <= conv_chan_i;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One register cycle; offsets at 7'h40 and up fall outside the window.
  task automatic acc(input logic w, input logic [6:0] off, input logic [31:0] d);
    @(negedge core_clk_i);
    req_i   = 1'b1;
    we_i    = w;
    addr_i  = base + {25'h000_0000, off};
    wdata_i = d;
    @(negedge core_clk_i);
    req_i = 1'b0;
    chk({31'h0000_0000, ack_o}, {31'h0000_0000, !off[6]});
    rd = rdata_o;
  endtask : acc
  task automatic stop_test;
    $display("Mismatches %0d, comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // A hang costs at most this span, 25000 cycles, far beyond the few hundred cycles needed.
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {rst_n_i, cfg_wr_i, cfg_rd_i, master_en_i, req_i, we_i, pacer_tick_i, ext_trig_i, dma_ready_i} = 9'h000;
    {cfg_wdata_i, addr_i, wdata_i, base, din_i} = 144'h0;
    ce_i = 1'b1;
    lat  = 4'h3;
    void'($urandom(32'h38ff134c));
    repeat (20) @(negedge core_clk_i);
    rst_n_i     = 1'b1;
    base        = $urandom & 32'h0000_ffc0;
    cfg_wdata_i = base | 32'h0000_0015;
    cfg_wr_i    = 1'b1;
    @(negedge core_clk_i);
    cfg_wr_i = 1'b0;
    cfg_rd_i = 1'b1;
    @(negedge core_clk_i);
    cfg_rd_i = 1'b0;
    chk(cfg_rdata_o, base | 32'h0000_0001);
    acc(1'b1, 7'h40, 32'h0000_0000);
    repeat (4) begin
      wd = $urandom;
      acc(1'b1, 7'h10, wd);
      chk({20'h0_0000, dac1_o}, {20'h0_0000, wd[11:0]});
      wd = ~wd;
      acc(1'b1, 7'h14, wd);
      chk({20'h0_0000, dac2_o}, {20'h0_0000, wd[11:0]});
      acc(1'b0, 7'h14, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      acc(1'b0, 7'h20, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      din_i = 16'($urandom);
      acc(1'b1, 7'h1c, wd);
      chk({16'h0000, dout_o}, {16'h0000, wd[15:0]});
      acc(1'b0, 7'h1c, 32'h0000_0000);
      chk(rd, {16'h0000, din_i});
    end
    // Timer port: a byte write to counter one, then a byte read of counter two.
    acc(1'b1, 7'h04, wd);
    chk({21'h0_0000, tmr_wr_o, tmr_sel_o, tmr_wdata_o}, {21'h0_0000, 1'b1, 2'h1, wd[7:0]});
    acc(1'b0, 7'h08, 32'h0000_0000);
    chk({29'h000_0000, tmr_rd_o, tmr_sel_o}, {29'h000_0000, 1'b1, 2'h2});
    chk(rd, {24'h00_0000, 8'(tmr_rdata_i - 8'h01)});
    // Clock enable low freezes the map: a write in the window is neither answered nor stored.
    wd = {20'h0_0000, ~dac2_o};
    @(negedge core_clk_i);
    ce_i    = 1'b0;
    req_i   = 1'b1;
    we_i    = 1'b1;
    addr_i  = base + 32'h0000_0014;
    wdata_i = wd;
    @(negedge core_clk_i);
    ce_i  = 1'b1;
    req_i = 1'b0;
    chk({31'h0000_0000, ack_o}, 32'h0000_0000);
    chk({20'h0_0000, dac2_o}, {20'h0_0000, ~wd[11:0]});
    // Software-triggered conversions, channel ends 0 and 15 first.
    for (int i = 0; i < 6; i++) begin
      ch  = (i < 2) ? 4'(i * 15) : 4'($urandom);
      g   = 4'($urandom);
      lat = 4'($urandom_range(1, 15));
      acc(1'b1, 7'h18, {19'h0_0000, g, ch, 1'b0, 4'h0});
      chk({24'h00_0000, gain_o, mux_sel_o}, {24'h00_0000, g, ch});
      acc(1'b1, 7'h20, $urandom);
      chk({31'h0000_0000, conv_start_o}, 32'h0000_0001);
      n = 0;
      while (!conv_done_i && n < 40) begin
        @(negedge core_clk_i);
        n++;
      end
      chk({31'h0000_0000, conv_done_i}, 32'h0000_0001);
      // Odd passes look at status first; even passes read the result the cycle after it lands.
      if (i % 2 == 1) begin
        acc(1'b0, 7'h18, 32'h0000_0000);
        chk(rd & 32'h0000_0001, 32'h0000_0001);
      end
      acc(1'b0, 7'h10, 32'h0000_0000);
      chk(rd, {16'h0000, code, chs});
      if (i % 2 == 0) begin
        acc(1'b0, 7'h18, 32'h0000_0000);
        chk(rd & 32'h0000_0001, 32'h0000_0000);
      end
      chk({28'h000_0000, chs}, {28'h000_0000, ch});
      acc(1'b1, 7'h10, ~rd);
      acc(1'b0, 7'h10, 32'h0000_0000);
      chk(rd, {16'h0000, code, chs});
    end
    // Mastering granted, external trigger; host stalls through two samples.
    master_en_i = 1'b1;
    lat         = 4'h2;
    acc(1'b1, 7'h18, 32'h0000_0009);
    repeat (2) begin
      @(negedge core_clk_i);
      ext_trig_i = 1'b1;
      @(negedge core_clk_i);
      ext_trig_i = 1'b0;
      repeat (8) @(negedge core_clk_i);
    end
    chk({31'h0000_0000, dma_valid_o}, 32'h0000_0001);
    chk(dma_data_o, {16'h0000, code, chs});
    dma_ready_i = 1'b1;
    @(negedge core_clk_i);
    dma_ready_i = 1'b0;
    chk({31'h0000_0000, dma_valid_o}, 32'h0000_0000);
    acc(1'b0, 7'h18, 32'h0000_0000);
    chk(rd & 32'h0000_0002, 32'h0000_0002);
    // Timer pacing with scan and interrupts: the channel walks 2, 1, 0 and wraps to 2.
    acc(1'b1, 7'h18, 32'h0000_0056);
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk_i);
      pacer_tick_i = 1'b1;
      @(negedge core_clk_i);
      pacer_tick_i = 1'b0;
      n = 0;
      while (!conv_done_i && n < 40) begin
        @(negedge core_clk_i);
        n++;
      end
      @(negedge core_clk_i);
      chk({31'h0000_0000, irq_o}, 32'h0000_0001);
      acc(1'b0, 7'h10, 32'h0000_0000);
      chk({28'h000_0000, chs}, {28'h000_0000, 4'(i == 3 ? 2 : 2 - i)});
      chk({31'h0000_0000, irq_o}, 32'h0000_0000);
    end
    stop_test();
  end
endmodule : daq_card_io_register_map_tb_top
`default_nettype wire

/* File: daq_conv_model.sv */
// Behavioural converter and timer standing behind the register map.
// Assumes start pulses come one at a time; latency is set per run by the bench.
`timescale 1ns/1ns
`default_nettype none
module daq_conv_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        start_i,
  input  wire logic [3:0]  chan_i,
  input  wire logic [3:0]  lat_i,
  output logic             done_o,
  output logic [11:0]      code_o,
  output logic [3:0]       chan_o,
  output logic [7:0]       tmr_o
);
  logic [3:0]  cnt_q;
  logic [11:0] code_q;
  logic [3:0]  ch_q;
  // ---------------------------------------------------------------
  // Conversion
  // ---------------------------------------------------------------
  // Latency from lat_i lets the bench try prompt and slow answers.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 4'h0;
      code_q <= 12'h5a3;
      ch_q   <= 4'h0;
      done_o <= 1'b0;
      tmr_o  <= 8'h00;
    end else begin
      done_o <= (cnt_q == 4'h1);
      tmr_o  <= tmr_o + 8'h01; // Idle data keeps moving, never a stale value.
      if (start_i) begin
        cnt_q  <= lat_i;
        code_q <= code_q + 12'h2b7;
        ch_q   <= chan_i;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
  // Outside the done pulse the lines show the inverse, so a late sample is caught.
  assign code_o = done_o ? code_q : ~code_q;
  assign chan_o = done_o ? ch_q : ~ch_q;
endmodule : daq_conv_model
`default_nettype wire

/* File: daq_io_pkg.sv */
// Constants shared by the acquisition card register map.
// Assumes a bus bridge in front that hands over one 32-bit access at a time.
// How it works
// - Every register access is one whole 32-bit word, and the card answers as a bus target.
// - In bus-master mode each conversion word is pushed toward host memory as a 32-bit burst word.
// - Offsets decode against the assigned base, and 0x10, 0x18 and 0x1C map to different registers on read and write.
// - Offset 0x10 reads a 12-bit conversion result inside a 32-bit word and ignores writes as a result register.
// - The top result bit is the most significant and the bottom one the least significant.
// - Each result read also returns the four-bit channel the sample came from.
// - Sixteen single-ended or eight differential inputs feed the converter, whose result lands in the result register.
// - Writes to 0x10 and 0x14 load converter output channels one and two, and neither can be read back.
// - Each output register keeps a 12-bit code and drops every other bit of the word.
// - The card asks for its base range and an interrupt through plug-and-play configuration.
`default_nettype none
package daq_io_pkg;
  // ---------------------------------------------------------------
  // Register offsets relative to the I/O base
  // ---------------------------------------------------------------
  localparam logic [5:0] OFF_COUNTER_0   = 6'h00;
  localparam logic [5:0] OFF_COUNTER_1   = 6'h04;
  localparam logic [5:0] OFF_COUNTER_2   = 6'h08;
  localparam logic [5:0] OFF_COUNTER_CTL = 6'h0c;
  localparam logic [5:0] OFF_ADC_DAC1    = 6'h10;
  localparam logic [5:0] OFF_DAC2        = 6'h14;
  localparam logic [5:0] OFF_STAT_CTL    = 6'h18;
  localparam logic [5:0] OFF_DIO         = 6'h1c;
  localparam logic [5:0] OFF_KICK        = 6'h20;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int RES_CH_LSB    = 0;
  localparam int RES_CODE_LSB  = 4;
  localparam int CTL_MODE_LSB  = 0;
  localparam int CTL_SCAN_BIT  = 4;
  localparam int CTL_MUX_LSB   = 5;
  localparam int CTL_GAIN_LSB  = 9;
  localparam int STS_DRDY_BIT  = 0;
  localparam int STS_DOVR_BIT  = 1;
  localparam int MODE_DMA_BIT  = 0;
  localparam int MODE_INT_BIT  = 1;
  localparam int MODE_TMR_BIT  = 2;
  localparam int MODE_EXT_BIT  = 3;
  // ---------------------------------------------------------------
  // Reset values and configuration
  // ---------------------------------------------------------------
  localparam logic [31:0] BASE_RESET  = 32'h0000_0000;
  localparam logic [31:0] BAR_MASK    = 32'hffff_ffc0;
  localparam logic [31:0] BAR_IO_FLAG = 32'h0000_0001;
  localparam logic [7:0]  IRQ_PIN     = 8'h01;
  localparam logic [11:0] DAC_RESET   = 12'h000;
  localparam logic [15:0] DOUT_RESET  = 16'h0000;
  localparam logic [12:0] CTL_RESET   = 13'h0000;
endpackage : daq_io_pkg
`default_nettype wire
